// file: pkg/adc_ctl_pkg.sv
// adc_ctl_pkg: register map, field positions, reset values and states of the converter control block.
// assumes a 32-bit AXI4-Lite bus where every register takes one aligned word.
`default_nettype none
package adc_ctl_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTL_A = 8'hE1;
    localparam logic [7:0] IDX_RES_HI = 8'hE2;
    localparam logic [7:0] IDX_CTL_B = 8'hE3;
    localparam logic [7:0] IDX_CFG = 8'hE4;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CTL_A = {2'h0, IDX_CTL_A, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RES_HI = {2'h0, IDX_RES_HI, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTL_B = {2'h0, IDX_CTL_B, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CFG = {2'h0, IDX_CFG, 2'h0};
    // control_a field positions
    localparam int A_CH0 = 0;
    localparam int A_CH1 = 1;
    localparam int A_SRC = 2;
    localparam int A_BUSY = 3;
    localparam int A_DONE = 4;
    localparam int A_EXT = 5;
    localparam int A_RLO = 6;
    // control_b field positions
    localparam int B_CH2 = 2;
    localparam int B_PRE = 6;
    // config field positions
    localparam int C_EN = 0;
    localparam int C_IRQ = 1;
    // reset values
    localparam logic [1:0] PRESCALE_RST = 2'h2;
    localparam logic [2:0] CHAN_RST = 3'h0;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // register selector codes
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_CTL_A = 3'h1,
        SEL_RES_HI = 3'h2,
        SEL_CTL_B = 3'h3,
        SEL_CFG = 3'h4
    } reg_sel_t;
    // conversion sequencer, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_STORE = 4'h4,
        ST_CLEAR = 4'h8
    } conv_state_t;
endpackage : adc_ctl_pkg
`default_nettype wire

// file: hdl/adc_conversion_control.sv
// adc_conversion_control: start/busy/done sequencing, clock selection and prescale, channel select
// and result registers of a 10-bit converter, reached over AXI4-Lite.
// assumes the converter core runs on aclk, takes a one-cycle start or abort pulse and returns
// a one-cycle done pulse with the result valid in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control #(
    parameter int RESULT_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [adc_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [adc_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_start_pin,
    input wire logic rc_osc_clk,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    output logic conv_start,
    output logic conv_abort,
    output logic [2:0] channel_select,
    output logic converter_clk_tick,
    output logic converter_enable,
    output logic conv_irq
);
    import adc_ctl_pkg::*;

    generate
        if (RESULT_W != 10) begin : g_bad_width
            $error("adc_conversion_control serves a 10-bit result only");
        end
    endgenerate

    // shared address decode for the read and write paths
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_CTL_A: decode = SEL_CTL_A;
            ADDR_RES_HI: decode = SEL_RES_HI;
            ADDR_CTL_B: decode = SEL_CTL_B;
            ADDR_CFG: decode = SEL_CFG;
            default: decode = SEL_NONE;
        endcase
    endfunction : decode

    logic aw_rdy_q, w_rdy_q, aw_hold_q, w_hold_q, bvalid_q, ar_rdy_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic done_q, busy_q, ext_en_q, src_q, enable_q, irq_en_q, irq_q;
    logic [2:0] chan_q;
    logic [1:0] pre_q;
    logic [7:0] res_hi_q;
    logic [1:0] res_lo_q;
    logic start_q, abort_q;
    conv_state_t state_q, state_d;
    logic [2:0] pin_sync_q, rc_sync_q;
    logic pin_lvl_q, rc_lvl_q;
    logic [2:0] div_q;
    logic tick_q;

    // write channel capture: address and data are taken separately, in either order
    wire aw_take = s_axi_awvalid && aw_rdy_q;
    wire w_take = s_axi_wvalid && w_rdy_q;
    wire wr_en = aw_hold_q && w_hold_q && !bvalid_q;
    wire reg_sel_t wr_sel = decode(awaddr_q);
    wire wr_lane0 = wr_en && wstrb_q[0];
    wire wr_a = wr_lane0 && (wr_sel == SEL_CTL_A);
    wire wr_b = wr_lane0 && (wr_sel == SEL_CTL_B);
    wire wr_c = wr_lane0 && (wr_sel == SEL_CFG);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_q <= 1'b0;
            w_rdy_q <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            aw_rdy_q <= s_axi_awvalid && !aw_rdy_q && !aw_hold_q;
            w_rdy_q <= s_axi_wvalid && !w_rdy_q && !w_hold_q;
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_en) begin
                aw_hold_q <= 1'b0;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_en) begin
                w_hold_q <= 1'b0;
            end
            if (wr_en) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read path; result high byte is read-only, control_a is read-only in part
    wire ar_take = s_axi_arvalid && ar_rdy_q;
    wire reg_sel_t rd_sel = decode(s_axi_araddr);
    wire [7:0] ctl_a_val = {res_lo_q, ext_en_q, done_q, busy_q, src_q, chan_q[1:0]};
    wire [7:0] ctl_b_val = {pre_q, 3'h0, chan_q[2], 2'h0};
    wire [7:0] cfg_val = {6'h00, irq_en_q, enable_q};
    wire [7:0] rd_byte = (rd_sel == SEL_CTL_A) ? ctl_a_val :
                         (rd_sel == SEL_RES_HI) ? res_hi_q :
                         (rd_sel == SEL_CTL_B) ? ctl_b_val :
                         (rd_sel == SEL_CFG) ? cfg_val : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            ar_rdy_q <= s_axi_arvalid && !ar_rdy_q && !rvalid_q;
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // pin and oscillator synchronisers; a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync_q <= 3'h0;
            rc_sync_q <= 3'h0;
            pin_lvl_q <= 1'b0;
            rc_lvl_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], external_start_pin};
            rc_sync_q <= {rc_sync_q[1:0], rc_osc_clk};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_lvl_q <= pin_sync_q[2];
            end
            if (rc_sync_q[1] == rc_sync_q[2]) begin
                rc_lvl_q <= rc_sync_q[2];
            end
        end
    end

    wire ext_edge = pin_sync_q[1] && pin_sync_q[2] && !pin_lvl_q;
    wire rc_edge = rc_sync_q[1] && rc_sync_q[2] && !rc_lvl_q;

    // start/stop decisions; a write that clears done may also start, per the same-access case
    wire sw_clear_done = wr_a && !wdata_q[A_DONE];
    wire done_eff = done_q && !sw_clear_done;
    wire sw_start = wr_a && wdata_q[A_BUSY];
    wire ext_start = ext_edge && ext_en_q;
    wire start_go = (state_q == ST_IDLE) && !busy_q && !done_eff && (sw_start || ext_start);
    wire abort_go = (state_q == ST_RUN) && wr_a && !wdata_q[A_BUSY];
    wire result_in = (state_q == ST_RUN) && conv_done && !abort_go;

    // sequencer: run, store result, set done, then drop busy
    always_comb begin
        case (state_q)
            ST_IDLE: state_d = start_go ? ST_RUN : ST_IDLE;
            ST_RUN: state_d = abort_go ? ST_IDLE : (result_in ? ST_STORE : ST_RUN);
            ST_STORE: state_d = ST_CLEAR;
            ST_CLEAR: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            start_q <= 1'b0;
            abort_q <= 1'b0;
            res_hi_q <= 8'h00;
            res_lo_q <= 2'h0;
        end else begin
            state_q <= state_d;
            start_q <= start_go;
            abort_q <= abort_go;
            if (start_go) begin
                busy_q <= 1'b1;
            end else if (abort_go || state_q == ST_CLEAR) begin
                busy_q <= 1'b0;
            end
            if (result_in) begin
                res_hi_q <= conv_result[9:2];
                res_lo_q <= conv_result[1:0];
            end
            // hardware set wins over a clear in the same cycle; software can never set it
            if (state_q == ST_STORE) begin
                done_q <= 1'b1;
            end else if (sw_clear_done) begin
                done_q <= 1'b0;
            end
        end
    end

    // configuration writes with their guards
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_en_q <= 1'b0;
            src_q <= 1'b0;
            chan_q <= CHAN_RST;
            pre_q <= PRESCALE_RST;
            enable_q <= 1'b0;
            irq_en_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= done_q && irq_en_q;
            if (wr_a) begin
                ext_en_q <= wdata_q[A_EXT];
            end
            if (wr_a && !enable_q) begin
                src_q <= wdata_q[A_SRC];
            end
            // channel moves only in the idle status; the guard uses the state before the write
            if (wr_a && !done_q && !busy_q) begin
                chan_q[1:0] <= {wdata_q[A_CH1], wdata_q[A_CH0]};
            end
            if (wr_b && !done_q && !busy_q) begin
                chan_q[2] <= wdata_q[B_CH2];
            end
            if (wr_b) begin
                pre_q <= wdata_q[B_PRE+1:B_PRE];
            end
            if (wr_c) begin
                enable_q <= wdata_q[C_EN];
                irq_en_q <= wdata_q[C_IRQ];
            end
        end
    end

    // converter clock: selected source ticks divided by 1/2/4/8; the rc source is slowed
    // by synchronisation, so it must sit well below half of aclk
    wire src_tick = src_q ? rc_edge : 1'b1;
    wire [2:0] div_last = (pre_q == 2'h0) ? 3'h0 : (pre_q == 2'h1) ? 3'h1 : (pre_q == 2'h2) ? 3'h3 : 3'h7;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= enable_q && src_tick && (div_q >= div_last);
            if (!enable_q) begin
                div_q <= 3'h0;
            end else if (src_tick) begin
                div_q <= (div_q >= div_last) ? 3'h0 : div_q + 3'h1;
            end
        end
    end

    // outputs, each straight from a flip-flop
    assign s_axi_awready = aw_rdy_q;
    assign s_axi_wready = w_rdy_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ar_rdy_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign conv_start = start_q;
    assign conv_abort = abort_q;
    assign channel_select = chan_q;
    assign converter_clk_tick = tick_q;
    assign converter_enable = enable_q;
    assign conv_irq = irq_q;

    a_done_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == ST_STORE |=> done_q && busy_q) else $error("done flag not set after store");
    a_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        done_q && irq_en_q |=> conv_irq) else $error("interrupt request missing");
    a_done_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        done_q && !sw_clear_done |=> !conv_start) else $error("start while done flag set");
    a_done_no_sw: assert property (@(posedge aclk) disable iff (!aresetn)
        !done_q && state_q != ST_STORE |=> !done_q) else $error("done flag set without result");
    a_start_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(conv_start) |-> busy_q && $past(sw_start || ext_start)) else $error("start without busy");
    a_busy_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == ST_STORE |=> busy_q ##1 (!busy_q && (done_q || $past(sw_clear_done))))
        else $error("busy not dropped after done");
    a_abort_run: assert property (@(posedge aclk) disable iff (!aresetn)
        abort_go |=> conv_abort && !busy_q && state_q == ST_IDLE) else $error("abort not carried out");
    a_busy_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
        busy_q |=> !conv_start) else $error("start accepted while busy");
    a_chan_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        done_q || busy_q |=> $stable(channel_select)) else $error("channel changed while not idle");
    a_src_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        enable_q |=> $stable(src_q)) else $error("clock source changed while enabled");
    a_result_first: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(done_q) |-> {res_hi_q, res_lo_q} == $past(conv_result, 2)) else $error("result not ready");
    a_ext_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_edge |=> !ext_edge) else $error("external start pulse too long");
endmodule : adc_conversion_control
`default_nettype wire

// file: tb/conv_core_model.sv
// conv_core_model: behavioural stand-in for the analog converter core.
// assumes start and abort arrive as one-cycle pulses on aclk; the result is the sample
// mixed with the channel code, so a wrong channel shows up in the result bits.
`timescale 1ns/1ps
`default_nettype none
module conv_core_model #(
    parameter int LATENCY = 40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic [2:0] channel_select,
    input wire logic [9:0] sample,
    output logic conv_done,
    output logic [9:0] conv_result
);
    int cnt;
    logic run;
    // result bus toggles outside the done cycle, so a late capture cannot pass by luck
    always @(posedge aclk) begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (!aresetn) begin
            run <= 1'b0;
            cnt <= 0;
            conv_result <= 10'h3FF;
        end else if (conv_abort) begin
            run <= 1'b0;
        end else if (conv_start) begin
            run <= 1'b1;
            cnt <= LATENCY;
        end else if (run && cnt == 1) begin
            run <= 1'b0;
            conv_done <= 1'b1;
            conv_result <= sample ^ {7'h00, channel_select};
        end else if (run) begin
            cnt <= cnt - 1;
        end
    end
endmodule : conv_core_model
`default_nettype wire

// file: tb/adc_conversion_control_tb_top.sv
// adc_conversion_control_tb_top: register-level tests of the converter control block.
// assumes the core model answers after a fixed latency and aclk runs at 200 MHz.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb_top;
    import adc_ctl_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, pin = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, conv_start, conv_abort, tick, en, irq, conv_done;
    logic [1:0] bresp, rresp;
    logic [2:0] ch;
    logic [9:0] conv_result, res;
    logic [9:0] sample = 10'h2D6;
    logic [2:0] rc_cnt = 3'h0;
    int err_count = 0, checked = 0, starts = 0, aborts = 0;
    adc_conversion_control adc_conversion_control_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .external_start_pin(pin), .rc_osc_clk(rc_cnt[2]), .conv_done(conv_done),
        .conv_result(conv_result), .conv_start(conv_start), .conv_abort(conv_abort), .channel_select(ch),
        .converter_clk_tick(tick), .converter_enable(en), .conv_irq(irq));
    conv_core_model conv_core_model_inst (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
        .conv_abort(conv_abort), .channel_select(ch), .sample(sample), .conv_done(conv_done),
        .conv_result(conv_result));
    // clock, slow rc stand-in (eight aclk cycles a period) and pulse counters
    initial forever #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        rc_cnt <= rc_cnt + 3'h1;
        if (conv_start === 1'b1) starts++;
        if (conv_abort === 1'b1) aborts++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // one write; address and data offered together, bready held until the response
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        check(32'(bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : rd
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(d, {24'h000000, e});
        check(32'(r), 32'(er));
    endtask : rdc
    // polls until the done flag shows, then lets the busy bit settle
    task automatic wait_done;
        logic [31:0] d;
        logic [1:0] r;
        do rd(ADDR_CTL_A, d, r); while (d[A_DONE] !== 1'b1);
        repeat (4) @(posedge aclk);
    endtask : wait_done
    task automatic ticks(output int n);
        n = 0;
        repeat (64) begin
            @(posedge aclk);
            if (tick === 1'b1) n++;
        end
    endtask : ticks
    initial begin
        int n, s0, a0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(ADDR_CTL_B, 8'h80, RESP_OKAY);
        rdc(ADDR_CTL_A, 8'h00, RESP_OKAY);
        rdc(12'h000, 8'h00, RESP_SLVERR);
        wr(12'h004, 8'hFF, RESP_SLVERR);
        // every prescale code; enable is dropped around each change
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_CFG, 8'h00, RESP_OKAY);
            wr(ADDR_CTL_B, {p[1:0], 6'h00}, RESP_OKAY);
            wr(ADDR_CFG, 8'h01, RESP_OKAY);
            ticks(n);
            check(32'(n >= (64 >> p) - 1 && n <= (64 >> p) + 1), 32'h1);
        end
        wr(ADDR_CTL_A, 8'h04, RESP_OKAY);
        rdc(ADDR_CTL_A, 8'h00, RESP_OKAY);
        wr(ADDR_CFG, 8'h02, RESP_OKAY);
        check(32'(en), 32'h0);
        ticks(n);
        check(32'(n), 32'h0);
        wr(ADDR_CTL_B, 8'h00, RESP_OKAY);
        wr(ADDR_CTL_A, 8'h04, RESP_OKAY);
        rdc(ADDR_CTL_A, 8'h04, RESP_OKAY);
        wr(ADDR_CFG, 8'h03, RESP_OKAY);
        ticks(n);
        check(32'(n >= 7 && n <= 9), 32'h1);
        wr(ADDR_CFG, 8'h02, RESP_OKAY);
        wr(ADDR_CTL_A, 8'h03, RESP_OKAY);
        wr(ADDR_CTL_B, 8'h84, RESP_OKAY);
        wr(ADDR_CFG, 8'h03, RESP_OKAY);
        check(32'(ch), 32'h7);
        check(32'(en), 32'h1);
        // start, refused restart with channel change, then completion
        s0 = starts;
        wr(ADDR_CTL_A, 8'h0B, RESP_OKAY);
        rdc(ADDR_CTL_A, 8'h0B, RESP_OKAY);
        wr(ADDR_CTL_A, 8'h08, RESP_OKAY);
        rdc(ADDR_CTL_A, 8'h0B, RESP_OKAY);
        check(32'(ch), 32'h7);
        check(32'(starts), 32'(s0 + 1));
        wait_done();
        res = sample ^ 10'h007;
        rdc(ADDR_RES_HI, res[9:2], RESP_OKAY);
        rdc(ADDR_CTL_A, {res[1:0], 6'h13}, RESP_OKAY);
        check(32'(irq), 32'h1);
        // done blocks a start; clearing and starting in one write restarts, then abort
        wr(ADDR_CTL_A, 8'h1B, RESP_OKAY);
        rdc(ADDR_CTL_A, {res[1:0], 6'h13}, RESP_OKAY);
        check(32'(starts), 32'(s0 + 1));
        a0 = aborts;
        wr(ADDR_CTL_A, 8'h0B, RESP_OKAY);
        wr(ADDR_CTL_A, 8'h03, RESP_OKAY);
        rdc(ADDR_CTL_A, {res[1:0], 6'h03}, RESP_OKAY);
        check(32'(starts), 32'(s0 + 2));
        check(32'(aborts), 32'(a0 + 1));
        check(32'(irq), 32'h0);
        wr(ADDR_CTL_A, 8'h13, RESP_OKAY);
        rdc(ADDR_CTL_A, {res[1:0], 6'h03}, RESP_OKAY);
        // external pin: ignored while disabled, one start per rising edge when enabled
        wr(ADDR_CTL_A, 8'h00, RESP_OKAY);
        s0 = starts;
        pin <= 1'b1;
        repeat (8) @(posedge aclk);
        pin <= 1'b0;
        repeat (8) @(posedge aclk);
        check(32'(starts), 32'(s0));
        sample <= 10'h155;
        wr(ADDR_CTL_A, 8'h20, RESP_OKAY);
        pin <= 1'b1;
        repeat (12) @(posedge aclk);
        pin <= 1'b0;
        check(32'(starts), 32'(s0 + 1));
        rdc(ADDR_CTL_A, {res[1:0], 6'h28}, RESP_OKAY);
        wait_done();
        // the ext-disable write left channel code 4, which the core mixes into the result
        res = 10'h155 ^ 10'h004;
        rdc(ADDR_RES_HI, res[9:2], RESP_OKAY);
        rdc(ADDR_CTL_A, {res[1:0], 6'h30}, RESP_OKAY);
        complete_run();
    end
    // watchdog: the tests need under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        complete_run();
    end
endmodule : adc_conversion_control_tb_top
`default_nettype wire
